/* rtl/ihs_pkg.sv */
// How it works
// - Reset leaves role select clear, so the block runs as a bus slave.
// - Own address comes from the address register; bytes pass the data register.
// - Start, matching address and direction bit set the byte-done flag.
// - Interrupt request only when flag, local enable and global enable are set.
// - Any software read or write of the data register clears the flag.
// - Second data access per flag event stops the block until interface reset.
// - With interrupt enabled, a request is raised at each acknowledged byte.
// - First byte of a transfer shows seven-bit address plus direction bit.
// - Direction flag holds slave's direction: set transmits, clear receives.
// - After a valid address, clock line is held low until flag is cleared.
// - Flag is set after each byte only when an acknowledge follows it.
// - Bytes keep flagging until a stop, which returns the slave to idle.
// - A not-acknowledge from the master returns the slave to idle.
// - The interface reset bit forces the bus side idle three link clock edges after the core registers it.
package ihs_pkg;

	// Register offsets on the plain register port
	localparam logic [1:0] IHS_OFF_CTRL = 2'h0;
	localparam logic [1:0] IHS_OFF_ADDR = 2'h1;
	localparam logic [1:0] IHS_OFF_DATA = 2'h2;
	localparam logic [1:0] IHS_OFF_IEN  = 2'h3;

	// Control and status field positions
	localparam int IHS_BIT_ROLE    = 0;
	localparam int IHS_BIT_IFRST   = 1;
	localparam int IHS_BIT_DIR     = 2;
	localparam int IHS_BIT_DONE    = 3;
	localparam int IHS_BIT_STOPPED = 4;
	localparam int IHS_BIT_IEN     = 0;

	// Bits per byte on the wire
	localparam logic [3:0] IHS_BYTE_BITS = 4'h8;

	typedef struct packed {
		logic [1:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} ihs_req_t;

	typedef struct packed {
		logic bus_clock_line;
		logic bus_data_line;
	} ihs_pins_in_t;

	typedef struct packed {
		logic bus_clock_line;
		logic bus_clock_oe;
		logic bus_data_line;
		logic bus_data_oe;
	} ihs_pins_out_t;

	typedef enum logic [2:0] {
		L_IDLE,
		L_ADDR,
		L_ADDR_ACK,
		L_RX,
		L_RX_ACK,
		L_TX,
		L_TX_ACK,
		L_HOLD
	} ihs_link_state_t;

	typedef struct packed {
		logic       role;
		logic       ifrst;
		logic       ien;
		logic [6:0] own_addr;
		logic [7:0] data;
		logic       dir;
		logic       flag;
		logic       serviced;
		logic       stopped;
		logic       rel_tgl;
		logic [2:0] ev_s;
		logic [7:0] rdata;
		logic       irq;
		logic       run;
	} ihs_core_st_t;

	typedef struct packed {
		logic [2:0]      scl_s;
		logic [2:0]      sda_s;
		logic            f_scl;
		logic            f_sda;
		logic [1:0]      run_s;
		logic [2:0]      rel_s;
		ihs_link_state_t state;
		logic            next_tx;
		logic [3:0]      cnt;
		logic [7:0]      sh;
		logic [7:0]      rx;
		logic            dir;
		logic            ack;
		logic            ev_tgl;
		logic            scl_oe;
		logic            sda_oe;
	} ihs_link_st_t;

	// Values after reset; role select clear means slave mode
	localparam ihs_core_st_t IHS_CORE_RST = '0;
	localparam ihs_link_st_t IHS_LINK_RST = '{
		scl_s: 3'h7, sda_s: 3'h7, f_scl: 1'b1, f_sda: 1'b1,
		state: L_IDLE, default: '0};

endpackage

/* rtl/ihs_slave.sv */
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
module ihs_slave import ihs_pkg::*; (
	input  wire logic          core_clk_i,
	input  wire logic          reset_n_i,
	input  wire logic          link_clk_i,
	input  wire ihs_req_t      reg_req_i,
	output logic        [7:0]  reg_rdata_o,
	input  wire logic          global_irq_enable_i,
	output logic               irq_o,
	input  wire ihs_pins_in_t  bus_in_i,
	output ihs_pins_out_t      bus_out_o
);

	ihs_core_st_t core_r;
	ihs_core_st_t core_nxt;
	ihs_link_st_t link_r;
	ihs_link_st_t link_nxt;
	logic   [1:0] lrst_r;

	logic data_acc;
	logic ev;
	logic rise;
	logic fall;
	logic start;
	logic stop;
	logic rel;

	function automatic logic hit(input ihs_req_t q, input logic [1:0] off);
		hit = q.addr == off;
	endfunction

	// Core domain: register file, flag and access policing
	always_comb begin
		core_nxt = core_r;
		core_nxt.ev_s = {core_r.ev_s[1:0], link_r.ev_tgl};
		ev = core_r.ev_s[1] ^ core_r.ev_s[2];
		data_acc = (reg_req_i.rd | reg_req_i.wr) & hit(reg_req_i, IHS_OFF_DATA);
		if (reg_req_i.wr && hit(reg_req_i, IHS_OFF_CTRL)) begin
			core_nxt.role = reg_req_i.wdata[IHS_BIT_ROLE];
			core_nxt.ifrst = reg_req_i.wdata[IHS_BIT_IFRST];
		end
		if (reg_req_i.wr && hit(reg_req_i, IHS_OFF_ADDR)) begin
			core_nxt.own_addr = reg_req_i.wdata[6:0];
		end
		if (reg_req_i.wr && hit(reg_req_i, IHS_OFF_IEN)) begin
			core_nxt.ien = reg_req_i.wdata[IHS_BIT_IEN];
		end
		if (reg_req_i.wr && hit(reg_req_i, IHS_OFF_DATA)) begin
			core_nxt.data = reg_req_i.wdata;
		end
		if (data_acc) begin
			if (core_r.serviced) begin
				core_nxt.stopped = 1'b1;
			end else begin
				core_nxt.serviced = 1'b1;
			end
			// Release is sent only against a raised flag, so a stray
			// early access cannot free a later stretch.
			if (core_r.flag) begin
				core_nxt.flag = 1'b0;
				core_nxt.rel_tgl = ~core_r.rel_tgl;
			end
		end
		// Set after clear, so only interface reset drops an event
		if (ev) begin
			core_nxt.flag = 1'b1;
			core_nxt.serviced = 1'b0;
			core_nxt.data = link_r.rx;
			core_nxt.dir = link_r.dir;
		end
		if (core_nxt.ifrst) begin
			core_nxt.flag = 1'b0;
			core_nxt.stopped = 1'b0;
			core_nxt.serviced = 1'b0;
		end
		core_nxt.run = ~core_nxt.role & ~core_nxt.ifrst & ~core_nxt.stopped;
		core_nxt.rdata = 8'h00;
		if (reg_req_i.rd) begin
			case (reg_req_i.addr)
				IHS_OFF_CTRL: begin
					core_nxt.rdata[IHS_BIT_ROLE] = core_r.role;
					core_nxt.rdata[IHS_BIT_IFRST] = core_r.ifrst;
					core_nxt.rdata[IHS_BIT_DIR] = core_r.dir;
					core_nxt.rdata[IHS_BIT_DONE] = core_r.flag;
					core_nxt.rdata[IHS_BIT_STOPPED] = core_r.stopped;
				end
				IHS_OFF_ADDR: core_nxt.rdata = {1'b0, core_r.own_addr};
				IHS_OFF_DATA: core_nxt.rdata = core_r.data;
				IHS_OFF_IEN: core_nxt.rdata[IHS_BIT_IEN] = core_r.ien;
				default: core_nxt.rdata = 8'h00;
			endcase
		end
		core_nxt.irq = core_nxt.flag & core_nxt.ien & global_irq_enable_i;
	end

	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			core_r <= IHS_CORE_RST;
		end else begin
			core_r <= core_nxt;
		end
	end

	// Link domain: reset is brought over as a level
	always_ff @(posedge link_clk_i) begin
		lrst_r <= {lrst_r[0], reset_n_i};
	end

	// Link domain: bus sequencing. Own address and transmit byte are read
	// across domains only while they stand still by protocol.
	always_comb begin
		link_nxt = link_r;
		link_nxt.scl_s = {link_r.scl_s[1:0], bus_in_i.bus_clock_line};
		link_nxt.sda_s = {link_r.sda_s[1:0], bus_in_i.bus_data_line};
		if (link_r.scl_s[1] == link_r.scl_s[2]) begin
			link_nxt.f_scl = link_r.scl_s[2];
		end
		if (link_r.sda_s[1] == link_r.sda_s[2]) begin
			link_nxt.f_sda = link_r.sda_s[2];
		end
		link_nxt.run_s = {link_r.run_s[0], core_r.run};
		link_nxt.rel_s = {link_r.rel_s[1:0], core_r.rel_tgl};
		rise = link_nxt.f_scl & ~link_r.f_scl;
		fall = ~link_nxt.f_scl & link_r.f_scl;
		start = link_r.f_sda & ~link_nxt.f_sda & link_nxt.f_scl & link_r.f_scl;
		stop = ~link_r.f_sda & link_nxt.f_sda & link_nxt.f_scl & link_r.f_scl;
		rel = link_r.rel_s[1] ^ link_r.rel_s[2];
		case (link_r.state)
			L_IDLE: link_nxt.state = L_IDLE;
			L_ADDR: begin
				if (rise) begin
					link_nxt.sh = {link_r.sh[6:0], link_nxt.f_sda};
					link_nxt.cnt = link_r.cnt + 4'h1;
				end else if (fall && link_r.cnt == IHS_BYTE_BITS) begin
					if (link_r.sh[7:1] == core_r.own_addr) begin
						link_nxt.sda_oe = 1'b1;
						link_nxt.dir = link_r.sh[0];
						link_nxt.next_tx = link_r.sh[0];
						link_nxt.state = L_ADDR_ACK;
					end else begin
						link_nxt.state = L_IDLE;
					end
				end
			end
			L_ADDR_ACK, L_RX_ACK: begin
				if (fall) begin
					link_nxt.sda_oe = 1'b0;
					link_nxt.rx = link_r.sh;
					link_nxt.ev_tgl = ~link_r.ev_tgl;
					link_nxt.scl_oe = 1'b1;
					link_nxt.state = L_HOLD;
				end
			end
			L_HOLD: begin
				if (rel) begin
					link_nxt.scl_oe = 1'b0;
					link_nxt.cnt = 4'h0;
					// First transmit bit appears as the clock is let go, so
					// setup rests on the master sampling late in its high phase.
					if (link_r.next_tx) begin
						link_nxt.sh = core_r.data;
						link_nxt.sda_oe = ~core_r.data[7];
						link_nxt.state = L_TX;
					end else begin
						link_nxt.state = L_RX;
					end
				end
			end
			L_RX: begin
				if (rise) begin
					link_nxt.sh = {link_r.sh[6:0], link_nxt.f_sda};
					link_nxt.cnt = link_r.cnt + 4'h1;
				end else if (fall && link_r.cnt == IHS_BYTE_BITS) begin
					link_nxt.sda_oe = 1'b1;
					link_nxt.state = L_RX_ACK;
				end
			end
			L_TX: begin
				if (fall) begin
					link_nxt.cnt = link_r.cnt + 4'h1;
					link_nxt.sh = {link_r.sh[6:0], 1'b0};
					if (link_nxt.cnt == IHS_BYTE_BITS) begin
						link_nxt.sda_oe = 1'b0;
						link_nxt.state = L_TX_ACK;
					end else begin
						link_nxt.sda_oe = ~link_r.sh[6];
					end
				end
			end
			L_TX_ACK: begin
				if (rise) begin
					link_nxt.ack = ~link_nxt.f_sda;
				end else if (fall) begin
					if (link_r.ack) begin
						link_nxt.ev_tgl = ~link_r.ev_tgl;
						link_nxt.scl_oe = 1'b1;
						link_nxt.state = L_HOLD;
					end else begin
						link_nxt.state = L_IDLE;
					end
				end
			end
			default: link_nxt.state = L_IDLE;
		endcase
		if (start) begin
			link_nxt.state = L_ADDR;
			link_nxt.cnt = 4'h0;
			link_nxt.sda_oe = 1'b0;
			link_nxt.scl_oe = 1'b0;
		end
		if (stop || !link_r.run_s[1]) begin
			link_nxt.state = L_IDLE;
			link_nxt.sda_oe = 1'b0;
			link_nxt.scl_oe = 1'b0;
		end
	end

	always_ff @(posedge link_clk_i) begin
		if (!lrst_r[1]) begin
			link_r <= IHS_LINK_RST;
		end else begin
			link_r <= link_nxt;
		end
	end

	assign reg_rdata_o = core_r.rdata;
	assign irq_o = core_r.irq;
	assign bus_out_o = '{bus_clock_line: 1'b0, bus_clock_oe: link_r.scl_oe,
		bus_data_line: 1'b0, bus_data_oe: link_r.sda_oe};

	property p_slave_after_reset;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		$rose(reset_n_i) |-> !core_r.role ##1 core_r.run;
	endproperty
	a_slave_after_reset: assert property (p_slave_after_reset)
		else $error("not in slave mode after reset");

	property p_own_addr;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		reg_req_i.wr && reg_req_i.addr == IHS_OFF_ADDR
		|=> core_r.own_addr == $past(reg_req_i.wdata[6:0]);
	endproperty
	a_own_addr: assert property (p_own_addr)
		else $error("own address not stored");

	property p_flag_set;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		ev && !core_nxt.ifrst
		|=> core_r.flag && core_r.data == $past(link_r.rx);
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("byte event did not raise flag with byte");

	property p_irq;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		##1 irq_o == ($past(global_irq_enable_i) && core_r.flag
			&& core_r.ien);
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt request mismatch");

	property p_autoclear;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		data_acc && core_r.flag && !ev |=> !core_r.flag;
	endproperty
	a_autoclear: assert property (p_autoclear)
		else $error("data access did not clear flag");

	property p_double_access;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		data_acc && core_r.serviced && !core_nxt.ifrst
		|=> core_r.stopped && !core_r.run;
	endproperty
	a_double_access: assert property (p_double_access)
		else $error("second access did not stop block");

	property p_dir;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		ev |=> core_r.dir == $past(link_r.dir);
	endproperty
	a_dir: assert property (p_dir)
		else $error("direction flag not captured");

	property p_stretch;
		@(posedge link_clk_i) disable iff (!lrst_r[1])
		link_r.state == L_HOLD |-> link_r.scl_oe;
	endproperty
	a_stretch: assert property (p_stretch)
		else $error("clock not held low while waiting");

	property p_nack_idle;
		@(posedge link_clk_i) disable iff (!lrst_r[1])
		link_r.state == L_TX_ACK && fall && !link_r.ack && !start
		|=> link_r.state == L_IDLE && !link_r.scl_oe;
	endproperty
	a_nack_idle: assert property (p_nack_idle)
		else $error("not idle after not-acknowledge");

	property p_stop_idle;
		@(posedge link_clk_i) disable iff (!lrst_r[1])
		stop |=> link_r.state == L_IDLE && !link_r.sda_oe;
	endproperty
	a_stop_idle: assert property (p_stop_idle)
		else $error("not idle after stop");

	property p_ifrst;
		@(posedge link_clk_i) disable iff (!lrst_r[1])
		!link_r.run_s[1] |=> link_r.state == L_IDLE && !link_r.scl_oe
			&& !link_r.sda_oe;
	endproperty
	a_ifrst: assert property (p_ifrst)
		else $error("interface reset did not force idle");

	property p_mismatch;
		@(posedge link_clk_i) disable iff (!lrst_r[1])
		link_r.state == L_ADDR && fall && link_r.cnt == IHS_BYTE_BITS
		&& link_r.sh[7:1] != core_r.own_addr && !stop
		|=> link_r.state == L_IDLE && !link_r.sda_oe;
	endproperty
	a_mismatch: assert property (p_mismatch)
		else $error("foreign address acknowledged");

	property p_irq_per_byte;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		$rose(core_r.flag) && core_r.ien && $past(global_irq_enable_i)
		|-> irq_o;
	endproperty
	a_irq_per_byte: assert property (p_irq_per_byte)
		else $error("no request at completed byte");

	property p_stray_access;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		data_acc && !core_r.flag
		|=> core_r.rel_tgl == $past(core_r.rel_tgl);
	endproperty
	a_stray_access: assert property (p_stray_access)
		else $error("release sent without a raised flag");

	property p_addr_capture;
		@(posedge link_clk_i) disable iff (!lrst_r[1])
		link_r.state == L_ADDR_ACK && fall && link_r.run_s[1]
		|=> link_r.state == L_HOLD && link_r.scl_oe
			&& link_r.rx == $past(link_r.sh);
	endproperty
	a_addr_capture: assert property (p_addr_capture)
		else $error("address byte not handed over");

	property p_hold_wait;
		@(posedge link_clk_i) disable iff (!lrst_r[1])
		link_r.state == L_HOLD && !rel && !start && !stop
		&& link_r.run_s[1] |=> link_r.state == L_HOLD && link_r.scl_oe;
	endproperty
	a_hold_wait: assert property (p_hold_wait)
		else $error("clock let go before flag was cleared");

	property p_rx_ack;
		@(posedge link_clk_i) disable iff (!lrst_r[1])
		link_r.state == L_RX && fall && link_r.cnt == IHS_BYTE_BITS
		&& link_r.run_s[1] |=> link_r.state == L_RX_ACK && link_r.sda_oe;
	endproperty
	a_rx_ack: assert property (p_rx_ack)
		else $error("received byte not acknowledged");

	property p_nack_no_flag;
		@(posedge link_clk_i) disable iff (!lrst_r[1])
		link_r.state == L_TX_ACK && fall && !link_r.ack
		|=> link_r.ev_tgl == $past(link_r.ev_tgl);
	endproperty
	a_nack_no_flag: assert property (p_nack_no_flag)
		else $error("byte event raised after not-acknowledge");

	property p_idle_quiet;
		@(posedge link_clk_i) disable iff (!lrst_r[1])
		link_r.state == L_IDLE |-> !link_r.sda_oe && !link_r.scl_oe;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet)
		else $error("bus line pulled while idle");

endmodule

/* dv/ihs_master.sv */
`timescale 1ns/10ps
module ihs_master (
	input  wire logic scl_w_i,
	input  wire logic sda_w_i,
	output logic      scl_o,
	output logic      sda_o
);
	localparam int Q = 300;
	int stall_err = 0;
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	// A stretch that never ends is counted rather than hung on
	task automatic rise();
		int n;
		n = 0;
		scl_o = 1'b1;
		while (scl_w_i !== 1'b1 && n < 400) begin
			#50;
			n++;
		end
		if (n >= 400)
			stall_err++;
		#Q;
	endtask
	task automatic start();
		sda_o = 1'b0;
		#Q;
		scl_o = 1'b0;
		#Q;
	endtask
	task automatic stop();
		sda_o = 1'b0;
		#Q;
		rise();
		sda_o = 1'b1;
		#Q;
	endtask
	// Reads pass all ones so the slave owns the data line
	task automatic xbyte(input logic [7:0] b, input logic ack_drv,
			output logic [7:0] got, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			sda_o = b[i];
			#Q;
			rise();
			got[i] = sda_w_i;
			scl_o = 1'b0;
			#Q;
		end
		sda_o = ack_drv;
		#Q;
		rise();
		ack = ~sda_w_i;
		scl_o = 1'b0;
		#Q;
		sda_o = 1'b1;
	endtask
endmodule

/* dv/ihs_slave_bench.sv */
`timescale 1ns/10ps
module ihs_slave_bench import ihs_pkg::*;;
	logic          core_clk;
	logic          link_clk;
	logic          reset_n;
	logic          gie;
	ihs_req_t      req;
	logic [7:0]    rdata;
	logic          irq;
	ihs_pins_in_t  pin_in;
	ihs_pins_out_t pin_out;
	logic          m_scl;
	logic          m_sda;
	logic [7:0]    q_exp[$];
	logic [7:0]    q_msk[$];
	logic [7:0]    mk;
	logic [7:0]    got;
	logic [7:0]    tx;
	logic          ack;
	logic          rd_d;
	int            n_mismatch;
	int            cmp_count;

	// Open drain with pull-ups: any party pulling low wins
	assign pin_in.bus_clock_line = m_scl & ~pin_out.bus_clock_oe;
	assign pin_in.bus_data_line  = m_sda & ~pin_out.bus_data_oe;

	ihs_slave i_dut (
		.core_clk_i         (core_clk),
		.reset_n_i          (reset_n),
		.link_clk_i         (link_clk),
		.reg_req_i          (req),
		.reg_rdata_o        (rdata),
		.global_irq_enable_i(gie),
		.irq_o              (irq),
		.bus_in_i           (pin_in),
		.bus_out_o          (pin_out)
	);
	ihs_master i_mst (
		.scl_w_i(pin_in.bus_clock_line),
		.sda_w_i(pin_in.bus_data_line),
		.scl_o  (m_scl),
		.sda_o  (m_sda)
	);

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	initial begin
		link_clk = 1'b0;
		#7;
		forever #24 link_clk = ~link_clk;
	end

	task automatic results();
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wreg(input logic [1:0] a, input logic [7:0] d);
		@(posedge core_clk);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk);
		req.wr <= 1'b0;
	endtask
	task automatic rreg(input logic [1:0] a, input logic [7:0] e,
			input logic [7:0] m);
		@(posedge core_clk);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		q_exp.push_back(e & m);
		q_msk.push_back(m);
		@(posedge core_clk);
		req.rd <= 1'b0;
	endtask
	task automatic wirq();
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 4000) begin
			@(posedge core_clk);
			n++;
		end
		chk({7'h00, irq}, 8'h01);
	endtask
	task automatic addr_byte(input logic [6:0] a, input logic d);
		i_mst.start();
		i_mst.xbyte({a, d}, 1'b1, got, ack);
	endtask

	// Read data stand only in the cycle after the strobe
	always @(posedge core_clk) begin
		if (rd_d) begin
			mk = q_msk.pop_front();
			chk(rdata & mk, q_exp.pop_front());
		end
		rd_d <= req.rd;
	end

	initial begin
		#400000;
		n_mismatch++;
		results();
	end

	initial begin
		req = '0;
		gie = 1'b1;
		reset_n = 1'b0;
		rd_d = 1'b0;
		n_mismatch = 0;
		cmp_count = 0;
		void'($urandom(3));
		// Link side needs several of its own edges inside reset
		repeat (6) @(posedge link_clk);
		@(posedge core_clk);
		reset_n <= 1'b1;
		repeat (10) @(posedge link_clk);
		rreg(IHS_OFF_CTRL, 8'h00, 8'hFF);
		chk({7'h00, irq}, 8'h00);
		wreg(IHS_OFF_ADDR, 8'h5A);
		wreg(IHS_OFF_IEN, 8'h01);
		$display("test reset done");

		addr_byte(7'h5A, 1'b0);
		chk({7'h00, ack}, 8'h01);
		wirq();
		rreg(IHS_OFF_CTRL, 8'h08, 8'h0C);
		rreg(IHS_OFF_DATA, 8'hB4, 8'hFF);
		repeat (2) @(posedge core_clk);
		chk({7'h00, irq}, 8'h00);
		tx = 8'($urandom);
		i_mst.xbyte(tx, 1'b1, got, ack);
		chk({7'h00, ack}, 8'h01);
		wirq();
		rreg(IHS_OFF_DATA, tx, 8'hFF);
		i_mst.stop();
		rreg(IHS_OFF_CTRL, 8'h00, 8'h08);
		$display("test receive done");

		@(posedge core_clk);
		gie <= 1'b0;
		addr_byte(7'h5A, 1'b1);
		repeat (100) @(posedge core_clk);
		chk({7'h00, irq}, 8'h00);
		chk({7'h00, pin_out.bus_clock_oe}, 8'h01);
		rreg(IHS_OFF_CTRL, 8'h0C, 8'h0C);
		tx = 8'($urandom);
		wreg(IHS_OFF_DATA, tx);
		i_mst.xbyte(8'hFF, 1'b0, got, ack);
		chk(got, tx);
		repeat (100) @(posedge core_clk);
		rreg(IHS_OFF_CTRL, 8'h08, 8'h08);
		wreg(IHS_OFF_DATA, ~tx);
		i_mst.xbyte(8'hFF, 1'b1, got, ack);
		chk(got, ~tx);
		repeat (100) @(posedge core_clk);
		rreg(IHS_OFF_CTRL, 8'h00, 8'h08);
		chk({7'h00, pin_out.bus_clock_oe}, 8'h00);
		i_mst.stop();
		@(posedge core_clk);
		gie <= 1'b1;
		$display("test transmit done");

		for (int i = 0; i < 2; i++) begin
			wreg(IHS_OFF_CTRL, 8'(i));
			addr_byte(i ? 7'h5A : 7'h11, 1'b0);
			chk({7'h00, ack}, 8'h00);
			repeat (100) @(posedge core_clk);
			rreg(IHS_OFF_CTRL, 8'h00, 8'h08);
			i_mst.stop();
		end
		wreg(IHS_OFF_CTRL, 8'h00);
		$display("test refuse done");

		addr_byte(7'h5A, 1'b0);
		wirq();
		wreg(IHS_OFF_CTRL, 8'h02);
		repeat (20) @(posedge link_clk);
		chk({7'h00, pin_out.bus_clock_oe}, 8'h00);
		wreg(IHS_OFF_CTRL, 8'h00);
		i_mst.stop();
		addr_byte(7'h5A, 1'b0);
		wirq();
		rreg(IHS_OFF_DATA, 8'hB4, 8'hFF);
		rreg(IHS_OFF_DATA, 8'hB4, 8'hFF);
		rreg(IHS_OFF_CTRL, 8'h10, 8'h18);
		i_mst.stop();
		wreg(IHS_OFF_CTRL, 8'h02);
		wreg(IHS_OFF_CTRL, 8'h00);
		rreg(IHS_OFF_CTRL, 8'h00, 8'h18);
		chk(8'(i_mst.stall_err), 8'h00);
		repeat (4) @(posedge core_clk);
		$display("test stop done");
		results();
	end
endmodule
